/* File: design/dpac_regs.svh */
`ifndef DPAC_REGS_SVH
`define DPAC_REGS_SVH

// ----------------------------------------------------------------
// Port select setting encodings
// ----------------------------------------------------------------
`define DPAC_DPS_JTAG4 3'h0
`define DPAC_DPS_JTAG5 3'h1
`define DPAC_DPS_SWD 3'h2
`define DPAC_DPS_SWD_SWV 3'h3
`define DPAC_DPS_DISABLED 3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DPAC_CLK_PERIOD_NS 40
`define DPAC_KEY_WINDOW_NS 8000
`define DPAC_KEY_WINDOW_CYC (`DPAC_KEY_WINDOW_NS / `DPAC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define DPAC_IR_IDCODE 4'h1
`define DPAC_IR_SCAN 4'h2
`define DPAC_IR_RESET_REQ 4'h8
`define DPAC_IR_BYPASS 4'hF
`define DPAC_IR_CAPTURE 4'h1
`define DPAC_IR_RESET_VAL 4'h1

// ----------------------------------------------------------------
// Data registers and pin claim positions
// ----------------------------------------------------------------
`define DPAC_RSTREQ_LEN 8
`define DPAC_RSTREQ_BIT 0
`define DPAC_PIN_CLK 0
`define DPAC_PIN_TMS 1
`define DPAC_PIN_TDI 2
`define DPAC_PIN_TDO 3
`define DPAC_PIN_TRST 4

`endif

/* File: design/dpac_pkg.sv */
package dpac_pkg;

    typedef enum logic [3:0] {
        DPAC_TLR = 4'h0,
        DPAC_RTI = 4'h1,
        DPAC_SEL_DR = 4'h3,
        DPAC_CAP_DR = 4'h2,
        DPAC_SHIFT_DR = 4'h6,
        DPAC_EXIT1_DR = 4'h7,
        DPAC_PAUSE_DR = 4'h5,
        DPAC_EXIT2_DR = 4'h4,
        DPAC_UPD_DR = 4'hC,
        DPAC_SEL_IR = 4'hD,
        DPAC_CAP_IR = 4'hF,
        DPAC_SHIFT_IR = 4'hE,
        DPAC_EXIT1_IR = 4'hA,
        DPAC_PAUSE_IR = 4'hB,
        DPAC_EXIT2_IR = 4'h9,
        DPAC_UPD_IR = 4'h8
    } dpac_tap_e;

endpackage

/* File: design/dpac_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module dpac_pin_sync import dpac_pkg::*; #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Pins and filtered levels
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } dpac_sync_s;

    dpac_sync_s st;
    dpac_sync_s next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = i_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A change counts only once the two later stages agree
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.level[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;

endmodule

`default_nettype wire

/* File: design/dpac_port_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

`include "dpac_regs.svh"

// Notes on behaviour
// R1: On-chip debug is off after reset; only firmware can switch it on.
// R2: Debug stays off until firmware that enables it runs after erase.
// R3: Active security lockout closes every programming, debug and test path.
// R4: Claimed pins: none, four or five scan, two wire, one trace, three.
// R5: Scan port follows 1149.1 on four pins, optional test reset fifth.
// R6: Scan port serves programming, debug, I/O scan chains and device chaining; the code decodes only ID, scan chain, reset request and bypass.
// R7: Host keeps test clock at most 14 MHz and CPU/3 or CPU/5.
// R8: Unconfigured part enables scan pins; disabled port frees them as GPIO.
// R9: Scan-written reset request honoured unless ports are disabled.
// R10: Default is four-wire scan with mode select pin input only.
// R11: Non-scan setting acquires over two-wire with bidirectional mode select.
// R12: Host puts no one-way buffer on mode select when two-wire is possible.
// R13: Host resets the TAP by mode select and test clock sequencing.
// R14: Shared pin is reset only on parts without dedicated reset pin.
// R15: Two-wire port opens only on key sequence inside window after reset.
// R16: Host clocks two-wire port at most one third of CPU clock.
// R17: Port select setting latched at reset, held until next reset.
module dpac_port_ctrl import dpac_pkg::*; #(
    parameter int SCAN_LEN = 8,
    parameter int KEY_LEN = 16,
    parameter logic [KEY_LEN-1:0] KEY_SEQ = 16'hA5C3,
    // Arbitrary neutral identity value
    parameter logic [31:0] IDCODE = 32'h0000_0001,
    parameter int KEY_WINDOW_CYC = `DPAC_KEY_WINDOW_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Straps and nonvolatile settings
    input wire logic [2:0] i_debug_port_select_setting,
    input wire logic i_security_lock,
    input wire logic i_no_dedicated_reset_pin,
    // Firmware control
    input wire logic i_fw_debug_enable,
    // Two-wire engine side
    input wire logic i_swdio_out,
    input wire logic i_swdio_drive,
    input wire logic i_swd_to_jtag,
    input wire logic i_swv_data,
    // Scan chain side
    input wire logic [SCAN_LEN-1:0] i_scan_capture,
    // Port pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    output logic o_tms_out,
    output logic o_tms_oe_n,
    output logic o_tdo,
    output logic o_tdo_oe_n,
    // Status and control out
    output logic o_on_chip_debug_logic_en,
    output logic o_jtag_active,
    output logic o_swd_active,
    output logic o_tms_bidir,
    output logic o_swd_sample,
    output logic o_swdio_in,
    output logic o_reset_req,
    output logic [SCAN_LEN-1:0] o_scan_update,
    output logic [4:0] o_gpio_claim,
    output logic [2:0] o_pins_used,
    output logic o_shared_pin_is_external_reset_pin
);

    localparam int WIN_W = $clog2(KEY_WINDOW_CYC + 1);
    localparam logic [WIN_W-1:0] WIN_END = WIN_W'(KEY_WINDOW_CYC);

    if (SCAN_LEN < 1 || SCAN_LEN > 32 || KEY_LEN < 1 || KEY_WINDOW_CYC < 1) begin : g_chk
        $error("dpac_port_ctrl: unsupported parameter values");
    end

    typedef struct packed {
        logic started;
        logic [2:0] debug_port_select_setting;
        logic locked;
        logic debug_en;
        logic tck_q;
        dpac_tap_e tap;
        logic [3:0] ir;
        logic [3:0] ir_sh;
        logic [31:0] dr;
        logic [SCAN_LEN-1:0] scan;
        logic [KEY_LEN-1:0] key_sh;
        logic [WIN_W-1:0] win_cnt;
        logic jtag_en;
        logic swd_en;
        logic tms_out;
        logic tms_oe_n;
        logic tdo;
        logic tdo_oe_n;
        logic swd_sample;
        logic swdio_in;
        logic reset_req;
        logic [4:0] claim;
        logic [2:0] used;
        logic shared_rst;
    } dpac_state_s;

    dpac_state_s st;
    dpac_state_s next_st;
    logic [3:0] pins;

    // Test clock must stay well under the system clock for edges to be seen [R7] [R16]
    dpac_pin_sync #(.W(4)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_pin({i_trst_n, i_tdi, i_tms, i_tck}),
        .o_level(pins)
    );

    // ----------------------------------------------------------------
    // TAP next state
    // ----------------------------------------------------------------
    function automatic dpac_tap_e tap_next(input dpac_tap_e s, input logic tms);
        case (s)
            DPAC_TLR: tap_next = tms ? DPAC_TLR : DPAC_RTI;
            DPAC_RTI: tap_next = tms ? DPAC_SEL_DR : DPAC_RTI;
            DPAC_SEL_DR: tap_next = tms ? DPAC_SEL_IR : DPAC_CAP_DR;
            DPAC_CAP_DR: tap_next = tms ? DPAC_EXIT1_DR : DPAC_SHIFT_DR;
            DPAC_SHIFT_DR: tap_next = tms ? DPAC_EXIT1_DR : DPAC_SHIFT_DR;
            DPAC_EXIT1_DR: tap_next = tms ? DPAC_UPD_DR : DPAC_PAUSE_DR;
            DPAC_PAUSE_DR: tap_next = tms ? DPAC_EXIT2_DR : DPAC_PAUSE_DR;
            DPAC_EXIT2_DR: tap_next = tms ? DPAC_UPD_DR : DPAC_SHIFT_DR;
            DPAC_UPD_DR: tap_next = tms ? DPAC_SEL_DR : DPAC_RTI;
            DPAC_SEL_IR: tap_next = tms ? DPAC_TLR : DPAC_CAP_IR;
            DPAC_CAP_IR: tap_next = tms ? DPAC_EXIT1_IR : DPAC_SHIFT_IR;
            DPAC_SHIFT_IR: tap_next = tms ? DPAC_EXIT1_IR : DPAC_SHIFT_IR;
            DPAC_EXIT1_IR: tap_next = tms ? DPAC_UPD_IR : DPAC_PAUSE_IR;
            DPAC_PAUSE_IR: tap_next = tms ? DPAC_EXIT2_IR : DPAC_PAUSE_IR;
            DPAC_EXIT2_IR: tap_next = tms ? DPAC_UPD_IR : DPAC_SHIFT_IR;
            DPAC_UPD_IR: tap_next = tms ? DPAC_SEL_DR : DPAC_RTI;
            default: tap_next = DPAC_TLR;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic scan_mode;
        logic [31:0] sh;
        int len;
        rise = 1'b0;
        fall = 1'b0;
        scan_mode = 1'b0;
        sh = '0;
        len = 1;
        next_st = st;
        next_st.tck_q = pins[0];
        next_st.swdio_in = pins[1];
        next_st.swd_sample = 1'b0;
        next_st.reset_req = 1'b0;
        rise = pins[0] & ~st.tck_q;
        fall = ~pins[0] & st.tck_q;

        if (!st.started) begin
            // Settings taken once, just after reset release [R17]
            next_st.started = 1'b1;
            next_st.debug_port_select_setting = i_debug_port_select_setting;
            next_st.locked = i_security_lock;
            next_st.shared_rst = i_no_dedicated_reset_pin; // [R14]
            scan_mode = (i_debug_port_select_setting == `DPAC_DPS_JTAG4) ||
                        (i_debug_port_select_setting == `DPAC_DPS_JTAG5);
            next_st.jtag_en = scan_mode & ~i_security_lock; // [R8] [R10] [R3]
        end else begin
            // Debug only by firmware, sticky to reset, never under lockout [R1] [R2] [R3]
            if (i_fw_debug_enable && !st.locked) begin
                next_st.debug_en = 1'b1;
            end

            // Two-wire key hunt in the window after reset [R15]
            if (st.win_cnt != WIN_END) begin
                next_st.win_cnt = st.win_cnt + 1'b1;
                if (rise) begin
                    next_st.key_sh = {st.key_sh[KEY_LEN-2:0], pins[1]};
                    if ({st.key_sh[KEY_LEN-2:0], pins[1]} == KEY_SEQ && !st.locked) begin
                        next_st.swd_en = 1'b1; // [R11] [R3]
                        next_st.jtag_en = 1'b0;
                    end
                end
            end
            // Two-wire engine hands the pins back to scan; pin goes input only [R11]
            if (st.swd_en && i_swd_to_jtag && !st.locked) begin
                next_st.swd_en = 1'b0;
                next_st.jtag_en = 1'b1;
            end
            if (st.swd_en && rise) begin
                next_st.swd_sample = 1'b1;
            end
        end

        // DR length follows the selected instruction; bypass chains devices [R6]
        case (st.ir)
            `DPAC_IR_IDCODE: len = 32;
            `DPAC_IR_SCAN: len = SCAN_LEN;
            `DPAC_IR_RESET_REQ: len = `DPAC_RSTREQ_LEN;
            default: len = 1;
        endcase

        if (!st.jtag_en) begin
            next_st.tap = DPAC_TLR;
            next_st.ir = `DPAC_IR_RESET_VAL;
        end else if (st.debug_port_select_setting == `DPAC_DPS_JTAG5 && !pins[3]) begin
            // Test reset pin only counts in five-wire mode [R5]
            next_st.tap = DPAC_TLR;
            next_st.ir = `DPAC_IR_RESET_VAL;
        end else if (rise) begin
            // Five high mode-select clocks reach reset from any state [R13] [R5]
            next_st.tap = tap_next(st.tap, pins[1]);
            case (st.tap)
                DPAC_TLR: next_st.ir = `DPAC_IR_RESET_VAL;
                DPAC_CAP_IR: next_st.ir_sh = `DPAC_IR_CAPTURE;
                DPAC_SHIFT_IR: next_st.ir_sh = {pins[2], st.ir_sh[3:1]};
                DPAC_UPD_IR: next_st.ir = st.ir_sh;
                DPAC_CAP_DR: begin
                    case (st.ir)
                        `DPAC_IR_IDCODE: next_st.dr = IDCODE;
                        `DPAC_IR_SCAN: next_st.dr = 32'(i_scan_capture); // [R6]
                        default: next_st.dr = '0;
                    endcase
                end
                DPAC_SHIFT_DR: begin
                    sh = st.dr >> 1;
                    sh[len-1] = pins[2];
                    next_st.dr = sh;
                end
                DPAC_UPD_DR: begin
                    if (st.ir == `DPAC_IR_SCAN) begin
                        next_st.scan = st.dr[SCAN_LEN-1:0]; // [R6]
                    end
                    if (st.ir == `DPAC_IR_RESET_REQ && st.dr[`DPAC_RSTREQ_BIT] &&
                        st.debug_port_select_setting != `DPAC_DPS_DISABLED) begin
                        next_st.reset_req = 1'b1; // [R9]
                    end
                end
                default: begin
                end
            endcase
        end

        // Output side: scan data on the falling test clock edge
        if (st.jtag_en) begin
            if (fall) begin
                if (st.tap == DPAC_SHIFT_DR) begin
                    next_st.tdo = st.dr[0];
                    next_st.tdo_oe_n = 1'b0;
                end else if (st.tap == DPAC_SHIFT_IR) begin
                    next_st.tdo = st.ir_sh[0];
                    next_st.tdo_oe_n = 1'b0;
                end else begin
                    next_st.tdo_oe_n = 1'b1;
                end
            end
        end else if (st.swd_en && st.debug_port_select_setting == `DPAC_DPS_SWD_SWV) begin
            next_st.tdo = i_swv_data;
            next_st.tdo_oe_n = 1'b0;
        end else begin
            next_st.tdo = 1'b0;
            next_st.tdo_oe_n = 1'b1;
        end

        // Mode select is driven only under the two-wire protocol [R10] [R11]
        next_st.tms_out = st.swd_en & i_swdio_out;
        next_st.tms_oe_n = ~(st.swd_en & i_swdio_drive);

        // Pin claims per configuration [R4] [R8] [R3]
        next_st.claim = '0;
        if (!st.started || st.locked || st.debug_port_select_setting == `DPAC_DPS_DISABLED) begin
            next_st.claim = '0;
        end else if (st.jtag_en) begin
            next_st.claim = 5'h0F;
            next_st.claim[`DPAC_PIN_TRST] = (st.debug_port_select_setting == `DPAC_DPS_JTAG5);
        end else if (st.swd_en || st.debug_port_select_setting == `DPAC_DPS_SWD || st.debug_port_select_setting == `DPAC_DPS_SWD_SWV) begin
            next_st.claim[`DPAC_PIN_CLK] = 1'b1;
            next_st.claim[`DPAC_PIN_TMS] = 1'b1;
            next_st.claim[`DPAC_PIN_TDO] = (st.debug_port_select_setting == `DPAC_DPS_SWD_SWV);
        end
        next_st.used = 3'(st.claim[0]) + 3'(st.claim[1]) + 3'(st.claim[2]) +
                       3'(st.claim[3]) + 3'(st.claim[4]);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st <= '0;
            st.tap <= DPAC_TLR;
            st.ir <= `DPAC_IR_RESET_VAL;
            st.locked <= 1'b1;
            st.tms_oe_n <= 1'b1;
            st.tdo_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_tms_out = st.tms_out;
    assign o_tms_oe_n = st.tms_oe_n;
    assign o_tdo = st.tdo;
    assign o_tdo_oe_n = st.tdo_oe_n;
    assign o_on_chip_debug_logic_en = st.debug_en;
    assign o_jtag_active = st.jtag_en;
    assign o_swd_active = st.swd_en;
    assign o_tms_bidir = st.swd_en;
    assign o_swd_sample = st.swd_sample;
    assign o_swdio_in = st.swdio_in;
    assign o_reset_req = st.reset_req;
    assign o_scan_update = st.scan;
    assign o_gpio_claim = st.claim;
    assign o_pins_used = st.used;
    assign o_shared_pin_is_external_reset_pin = st.shared_rst;

endmodule

`default_nettype wire

/* File: design/dpac_top_unused_placeholder.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: dv/dpac_port_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module dpac_port_ctrl_asserts (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // Watched ports
    input wire logic i_fw_debug_enable,
    input wire logic o_on_chip_debug_logic_en,
    input wire logic o_jtag_active,
    input wire logic o_swd_active,
    input wire logic o_tms_bidir,
    input wire logic o_tms_oe_n,
    input wire logic o_tdo_oe_n,
    input wire logic o_reset_req,
    input wire logic o_swd_sample,
    input wire logic [4:0] o_gpio_claim,
    input wire logic [2:0] o_pins_used
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    property p_dbg_cause;
        $rose(o_on_chip_debug_logic_en) |-> $past(i_fw_debug_enable);
    endproperty
    a_dbg_cause: assert property (p_dbg_cause) else $error("debug on without firmware");
    property p_dbg_sticky;
        o_on_chip_debug_logic_en |=> o_on_chip_debug_logic_en;
    endproperty
    a_dbg_sticky: assert property (p_dbg_sticky) else $error("debug enable dropped");
    property p_one_port;
        !(o_jtag_active && o_swd_active);
    endproperty
    a_one_port: assert property (p_one_port) else $error("both ports active");
    property p_tms_in_only;
        !o_tms_oe_n |-> o_swd_active || $past(o_swd_active);
    endproperty
    a_tms_in_only: assert property (p_tms_in_only) else $error("mode pin driven in scan");
    property p_bidir;
        o_tms_bidir == o_swd_active;
    endproperty
    a_bidir: assert property (p_bidir) else $error("bidir flag wrong");
    property p_pins;
        o_pins_used == 3'($countones($past(o_gpio_claim)));
    endproperty
    a_pins: assert property (p_pins) else $error("pin count wrong");
    property p_rst_pulse;
        o_reset_req |-> o_jtag_active ##1 !o_reset_req;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request bad");
    property p_sample;
        o_swd_sample |-> o_swd_active ##1 !o_swd_sample;
    endproperty
    a_sample: assert property (p_sample) else $error("sample pulse bad");
    property p_tdo_oe;
        !o_tdo_oe_n |-> o_jtag_active || o_swd_active || $past(o_jtag_active);
    endproperty
    a_tdo_oe: assert property (p_tdo_oe) else $error("data out driven while off");
endmodule

`default_nettype wire

/* File: dv/dpac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dpac_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Port pins
    input wire logic i_tdo,
    output logic o_tck = 1'b0,
    output logic o_tms = 1'b1,
    output logic o_tdi = 1'b0
);
    // One test clock of 320 ns; stands low between frames
    task automatic bit_(input logic tms, input logic tdi, output logic tdo);
        o_tck <= 1'b0;
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (4) @(posedge i_sys_clk);
        o_tck <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        tdo = i_tdo;
        repeat (2) @(posedge i_sys_clk);
    endtask
    // Frame end: clock back low, then time for the device's pin filter to act
    task automatic idle_();
        o_tck <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
    endtask
    // Mode pin is driven open to the device, no one-way buffer
    task automatic reset_tap();
        logic b;
        for (int i = 0; i < 5; i++) bit_(1'b1, 1'b0, b);
        bit_(1'b0, 1'b0, b);
        idle_();
    endtask
    task automatic shift(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic b;
        dout = '0;
        bit_(1'b1, 1'b0, b);
        if (ir) bit_(1'b1, 1'b0, b);
        bit_(1'b0, 1'b0, b);
        bit_(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            bit_(i == n - 1, din[i], b);
            dout[i] = b;
        end
        bit_(1'b1, 1'b0, b);
        bit_(1'b0, 1'b0, b);
        idle_();
    endtask
    task automatic send_key(input logic [15:0] k);
        logic b;
        for (int i = 15; i >= 0; i--) bit_(k[i], 1'b0, b);
        idle_();
    endtask
endmodule

`default_nettype wire

/* File: dv/debug_port_access_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpac_regs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end

module debug_port_access_control_bench;
    typedef struct packed {
        logic [2:0] sel; logic strap; logic [4:0] claim; logic [2:0] pins; logic jtag;
    } dpac_row_s;
    localparam logic [31:0] ID = 32'h0000_0B5D; // Arbitrary value
    localparam logic [15:0] KEY = 16'hA5C3;
    localparam dpac_row_s ROWS [5] = '{'{`DPAC_DPS_JTAG4, 1'b0, 5'h0F, 3'h4, 1'b1},
        '{`DPAC_DPS_JTAG5, 1'b1, 5'h1F, 3'h5, 1'b1}, '{`DPAC_DPS_SWD, 1'b0, 5'h03, 3'h2, 1'b0},
        '{`DPAC_DPS_SWD_SWV, 1'b1, 5'h0B, 3'h3, 1'b0}, '{`DPAC_DPS_DISABLED, 1'b0, 5'h00, 3'h0, 1'b0}};
    logic clk = 1'b0, rstn = 1'b0, lock = 1'b0, strap = 1'b0, fw_en = 1'b0;
    logic sw_out = 1'b0, sw_drv = 1'b0, sw2j = 1'b0;
    logic [2:0] sel = 3'h0;
    logic tck, host_tms, tdi, tdo, tdo_oe_n, tms_out, tms_oe_n, dbg_en, jtag, swd, bidir;
    logic rst_req;
    logic swv = 1'b0, trstn = 1'b1, swdio_in;
    logic [7:0] upd;
    logic [4:0] claim;
    logic [2:0] pins;
    logic shrd;
    logic [31:0] d;
    wire logic tms_pin;
    int num_errors = 0, checks_done = 0, rst_cnt = 0;

    assign tms_pin = tms_oe_n ? host_tms : tms_out;
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (rst_req === 1'b1) rst_cnt++;

    dpac_host_model u_host (.i_sys_clk(clk), .i_tdo(tdo), .o_tck(tck), .o_tms(host_tms),
        .o_tdi(tdi));
    dpac_port_ctrl #(.KEY_SEQ(KEY), .IDCODE(ID)) u_dut (.i_sys_clk(clk), .i_resetn(rstn),
        .i_debug_port_select_setting(sel), .i_security_lock(lock),
        .i_no_dedicated_reset_pin(strap), .i_fw_debug_enable(fw_en), .i_swdio_out(sw_out),
        .i_swdio_drive(sw_drv), .i_swd_to_jtag(sw2j), .i_swv_data(swv),
        .i_scan_capture(8'hC3), .i_tck(tck), .i_tms(tms_pin), .i_tdi(tdi), .i_trst_n(trstn),
        .o_tms_out(tms_out), .o_tms_oe_n(tms_oe_n), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
        .o_on_chip_debug_logic_en(dbg_en), .o_jtag_active(jtag), .o_swd_active(swd),
        .o_tms_bidir(bidir), .o_swd_sample(), .o_swdio_in(swdio_in), .o_reset_req(rst_req),
        .o_scan_update(upd), .o_gpio_claim(claim), .o_pins_used(pins),
        .o_shared_pin_is_external_reset_pin(shrd));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic do_reset(input logic [2:0] s, input logic lk, input logic st);
        sel <= s;
        lock <= lk;
        strap <= st;
        sw_drv <= 1'b0;
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (12) @(posedge clk);
    endtask
    task automatic fw_pulse();
        fw_en <= 1'b1;
        @(posedge clk);
        fw_en <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ----
    // Table, then hand-written cases
    // ----
    initial begin
        for (int i = 0; i < 5; i++) begin
            do_reset(ROWS[i].sel, 1'b0, ROWS[i].strap);
            `CHK("claim", ROWS[i].claim, claim)
            `CHK("pins", ROWS[i].pins, pins)
            `CHK("jtag", ROWS[i].jtag, jtag)
            `CHK("debug", 1'b0, dbg_en)
            `CHK("shared", ROWS[i].strap, shrd)
        end
        do_reset(`DPAC_DPS_JTAG4, 1'b0, 1'b0);
        sw_drv <= 1'b1;
        sel <= `DPAC_DPS_DISABLED;
        repeat (4) @(posedge clk);
        `CHK("tms oe", 1'b1, tms_oe_n)
        `CHK("held claim", 5'h0F, claim)
        sw_drv <= 1'b0;
        u_host.reset_tap();
        u_host.shift(1'b0, 32, 32'h0, d);
        `CHK("idcode", ID, d)
        u_host.shift(1'b1, 4, `DPAC_IR_SCAN, d);
        `CHK("ir capture", `DPAC_IR_CAPTURE, d[3:0])
        u_host.shift(1'b0, 8, 32'h5A, d);
        `CHK("scan out", 8'hC3, d[7:0])
        `CHK("scan upd", 8'h5A, upd)
        u_host.shift(1'b1, 4, `DPAC_IR_RESET_REQ, d);
        u_host.shift(1'b0, 8, 32'h01, d);
        `CHK("reset req", 1, rst_cnt)
        fw_pulse();
        `CHK("debug on", 1'b1, dbg_en)
        repeat (5) @(posedge clk);
        `CHK("debug held", 1'b1, dbg_en)
        do_reset(`DPAC_DPS_DISABLED, 1'b0, 1'b0);
        // Scan reached via two-wire, so only the setting check can refuse
        u_host.send_key(KEY);
        sw2j <= 1'b1;
        @(posedge clk);
        sw2j <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("disabled scan", 1'b1, jtag)
        u_host.reset_tap();
        u_host.shift(1'b1, 4, `DPAC_IR_RESET_REQ, d);
        u_host.shift(1'b0, 8, 32'h01, d);
        `CHK("reset refused", 1, rst_cnt)
        do_reset(`DPAC_DPS_SWD, 1'b0, 1'b0);
        u_host.send_key(KEY);
        repeat (4) @(posedge clk);
        `CHK("swd", 1'b1, swd)
        `CHK("bidir", 1'b1, bidir)
        sw_drv <= 1'b1;
        sw_out <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("tms drive", 1'b0, tms_oe_n)
        `CHK("tms out", 1'b1, tms_out)
        sw_drv <= 1'b0;
        sw2j <= 1'b1;
        @(posedge clk);
        sw2j <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("to scan", 1'b1, jtag)
        `CHK("in only", 1'b0, bidir)
        do_reset(`DPAC_DPS_SWD, 1'b0, 1'b0);
        repeat (250) @(posedge clk);
        u_host.send_key(KEY);
        `CHK("late key", 1'b0, swd)
        do_reset(`DPAC_DPS_SWD_SWV, 1'b0, 1'b0);
        u_host.send_key(KEY);
        swv <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("trace oe", 1'b0, tdo_oe_n)
        `CHK("trace out", 1'b1, tdo)
        `CHK("trace claim", 5'h0B, claim)
        `CHK("data in", 1'b1, swdio_in)
        swv <= 1'b0;
        do_reset(`DPAC_DPS_JTAG5, 1'b0, 1'b0);
        u_host.reset_tap();
        u_host.shift(1'b1, 4, `DPAC_IR_SCAN, d);
        trstn <= 1'b0;
        repeat (8) @(posedge clk);
        trstn <= 1'b1;
        repeat (8) @(posedge clk);
        u_host.bit_(1'b0, 1'b0, d[0]);
        u_host.shift(1'b0, 32, 32'h0, d);
        `CHK("trst idcode", ID, d)
        do_reset(`DPAC_DPS_JTAG4, 1'b1, 1'b0);
        `CHK("lock jtag", 1'b0, jtag)
        `CHK("lock claim", 5'h00, claim)
        fw_pulse();
        u_host.send_key(KEY);
        `CHK("lock debug", 1'b0, dbg_en)
        `CHK("lock swd", 1'b0, swd)
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule

bind dpac_port_ctrl dpac_port_ctrl_asserts u_chk (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_fw_debug_enable(i_fw_debug_enable), .o_on_chip_debug_logic_en(o_on_chip_debug_logic_en),
    .o_jtag_active(o_jtag_active), .o_swd_active(o_swd_active), .o_tms_bidir(o_tms_bidir),
    .o_tms_oe_n(o_tms_oe_n), .o_tdo_oe_n(o_tdo_oe_n), .o_reset_req(o_reset_req),
    .o_swd_sample(o_swd_sample), .o_gpio_claim(o_gpio_claim), .o_pins_used(o_pins_used));

`default_nettype wire
